// File: shared/tpg_pkg.sv
// Purpose: constants for the three-port gpio block
// Assumes: byte-wide register port, 8-bit addresses
// Notes: offsets are byte addresses on the register port
package tpg_pkg;
	localparam logic [7:0] ADDR_P0_DATA = 8'hE0;
	localparam logic [7:0] ADDR_P1_DATA = 8'hE1;
	localparam logic [7:0] ADDR_P2_DATA = 8'hE2;
	localparam logic [7:0] ADDR_P0_CFGH = 8'hE6;
	localparam logic [7:0] ADDR_P0_CFGL = 8'hE7;
	localparam logic [7:0] ADDR_P0_PEND = 8'hE8;
	localparam logic [7:0] ADDR_P1_CFG = 8'hE9;
	localparam logic [7:0] ADDR_P2_CFGH = 8'hEA;
	localparam logic [7:0] ADDR_P2_CFGL = 8'hEB;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam int P0_PINS = 8;
	localparam int P1_PINS = 2;
	localparam int P2_PINS = 7;
	// port one config fields
	localparam int P1_OD_BIT = 7;
	localparam int P1_MODE_LSB = 2;
	localparam logic [1:0] P1M_IN = 2'h0;
	localparam logic [1:0] P1M_IN_PU = 2'h1;
	localparam logic [1:0] P1M_OUT = 2'h2;
	localparam logic [1:0] P1M_IN_PD = 2'h3;
	// port two two-bit field codes
	localparam logic [1:0] P2M_IN_PU = 2'h0;
	localparam logic [1:0] P2M_IN = 2'h1;
	localparam logic [1:0] P2M_PP = 2'h2;
	localparam logic [1:0] P2M_OD = 2'h3;
	// port two pin six codes, bits 6:4 of the high byte
	localparam int P2_PIN6_LSB = 4;
	localparam logic [2:0] P26_IN_PU = 3'h0;
	localparam logic [2:0] P26_IN = 3'h1;
	localparam logic [2:0] P26_PP = 3'h4;
	localparam logic [2:0] P26_OD_PU = 3'h5;
	localparam logic [2:0] P26_OD = 3'h6;
	localparam logic [2:0] P26_CLO = 3'h7;
	// port zero two-bit field codes
	localparam logic [1:0] P0M_IN = 2'h0;
	localparam logic [1:0] P0M_IN_PU = 2'h1;
	localparam logic [1:0] P0M_PP = 2'h2;
	localparam logic [1:0] P0M_ALT = 2'h3;
endpackage

// File: design/tpg_gpio.sv
// Purpose: three bit-programmable gpio ports behind a byte register port
// Assumes: pins are sampled through two flops; analog paths live outside
// Notes: pin output enables are active low (low = drive)
// What this block does
// - three ports, seventeen pins, data registers
// - port zero data at E0, pins
// - port one data register at E1
// - port two data register at E2
// - reset clears all data registers
// - port zero pins input/push-pull, pull-up
// - port zero config at E6, E7, E8
// - port zero alternates: interrupt, pwm
// - port one two pins, modes, pulls
// - option selects osc out, reset input
// - reset-capable pin never drives output
// - port one config register at E9
// - config bit 7 selects open-drain
// - config bits 3:2 set pin mode
// - port two seven pins, alternates
// - port two config at EA, EB
// - high byte fields for pins four, five
// - high byte bits 6:4 for pin six
//
// The strobed register port was chosen for this implementation.
module tpg_gpio
	import tpg_pkg::*;
(
	input wire logic clk, // 250 MHz system clock
	input wire logic resetn, // async active-low reset
	input wire logic [7:0] addr, // register address
	input wire logic [7:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [7:0] rdata, // read data, cycle after rd
	input wire logic [P0_PINS-1:0] p0_in, // port zero pin levels
	output logic [P0_PINS-1:0] p0_out, // port zero drive value
	output logic [P0_PINS-1:0] p0_oe_n, // port zero drive enable, low drives
	output logic [P0_PINS-1:0] p0_pu, // port zero pull-up enables
	output logic [P0_PINS-1:0] p0_alt_sel, // port zero alternate function select
	output logic [P0_PINS-1:0] p0_irq_pin, // synchronized level to interrupt logic
	input wire logic [P0_PINS-1:0] p0_pwm, // pwm value for alternate pins
	input wire logic [P1_PINS-1:0] p1_in, // port one pin levels
	output logic [P1_PINS-1:0] p1_out, // port one drive value
	output logic [P1_PINS-1:0] p1_oe_n, // port one drive enable, low drives
	output logic [P1_PINS-1:0] p1_pu, // port one pull-ups
	output logic [P1_PINS-1:0] p1_pd, // port one pull-downs
	input wire logic opt_osc_en, // option: pin one is oscillator output
	input wire logic opt_rst_en, // option: pin two is reset input
	input wire logic osc_clk_out, // oscillator output for pin one
	output logic ext_reset_n, // synchronized reset pin level
	input wire logic [P2_PINS-1:0] p2_in, // port two pin levels
	output logic [P2_PINS-1:0] p2_out, // port two drive value
	output logic [P2_PINS-1:0] p2_oe_n, // port two drive enable, low drives
	output logic [P2_PINS-1:0] p2_pu, // port two pull-ups
	output logic [P2_PINS-1:0] p2_adc_sel, // port two adc input select
	input wire logic clo_val, // clock output value for pin six
	input wire logic tmr_match // timer match output value
);

	// ********************************
	// reset release and pin sync
	// ********************************
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [16:0] pin_s1_r;
	logic [16:0] pin_s2_r;
	assign rst_n = rst_sync_r[1];
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	// second stage only feeds logic
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_r <= 17'h00000;
			pin_s2_r <= 17'h00000;
		end
		else
		begin
			pin_s1_r <= {p2_in, p1_in, p0_in};
			pin_s2_r <= pin_s1_r;
		end
	end
	logic [P0_PINS-1:0] p0_sync;
	logic [P1_PINS-1:0] p1_sync;
	logic [P2_PINS-1:0] p2_sync;
	assign p0_sync = pin_s2_r[7:0];
	assign p1_sync = pin_s2_r[9:8];
	assign p2_sync = pin_s2_r[16:10];

	// ********************************
	// registers
	// ********************************
	logic [7:0] p0_data_r, p1_data_r, p2_data_r;
	logic [7:0] p0_cfgh_r, p0_cfgl_r, p0_pend_r, p1_cfg_r, p2_cfgh_r, p2_cfgl_r;
	logic [7:0] rdata_r, rdata_nxt;
	logic w_p0, w_p1, w_p2, w_p0h, w_p0l, w_p0p, w_p1c, w_p2h, w_p2l;
	assign w_p0 = wr && addr == ADDR_P0_DATA;
	assign w_p1 = wr && addr == ADDR_P1_DATA;
	assign w_p2 = wr && addr == ADDR_P2_DATA;
	assign w_p0h = wr && addr == ADDR_P0_CFGH;
	assign w_p0l = wr && addr == ADDR_P0_CFGL;
	assign w_p0p = wr && addr == ADDR_P0_PEND;
	assign w_p1c = wr && addr == ADDR_P1_CFG;
	assign w_p2h = wr && addr == ADDR_P2_CFGH;
	assign w_p2l = wr && addr == ADDR_P2_CFGL;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			p0_data_r <= RST_DATA;
			p1_data_r <= RST_DATA;
			p2_data_r <= RST_DATA;
			p0_cfgh_r <= RST_CFG;
			p0_cfgl_r <= RST_CFG;
			p0_pend_r <= RST_CFG;
			p1_cfg_r <= RST_CFG;
			p2_cfgh_r <= RST_CFG;
			p2_cfgl_r <= RST_CFG;
			rdata_r <= 8'h00;
		end
		else
		begin
			if (w_p0) p0_data_r <= wdata;
			if (w_p1) p1_data_r <= wdata;
			if (w_p2) p2_data_r <= wdata;
			if (w_p0h) p0_cfgh_r <= wdata;
			if (w_p0l) p0_cfgl_r <= wdata;
			// pending logic lives in the interrupt block; stored only
			if (w_p0p) p0_pend_r <= wdata;
			if (w_p1c) p1_cfg_r <= wdata;
			if (w_p2h) p2_cfgh_r <= wdata;
			if (w_p2l) p2_cfgl_r <= wdata;
			rdata_r <= rdata_nxt;
		end
	end

	// ********************************
	// per-pin configuration decode
	// ********************************
	function automatic logic [1:0] fld(input logic [15:0] cfg, input int i);
		fld = cfg[2*i +: 2];
	endfunction

	logic [15:0] p0_cfg;
	logic [15:0] p2_cfg;
	assign p0_cfg = {p0_cfgh_r, p0_cfgl_r};
	assign p2_cfg = {p2_cfgh_r, p2_cfgl_r};

	logic [P0_PINS-1:0] p0_drv;
	logic [P2_PINS-1:0] p2_drv, p2_od, p2_alt_val;
	logic [2:0] p26_mode;
	assign p26_mode = p2_cfgh_r[P2_PIN6_LSB +: 3];

	always_comb
	begin
		for (int i = 0; i < P0_PINS; i++)
		begin
			p0_drv[i] = fld(p0_cfg, i) == P0M_PP || fld(p0_cfg, i) == P0M_ALT;
			p0_pu[i] = fld(p0_cfg, i) == P0M_IN_PU;
			p0_alt_sel[i] = fld(p0_cfg, i) == P0M_ALT;
		end
		for (int i = 0; i < P2_PINS - 1; i++)
		begin
			p2_drv[i] = fld(p2_cfg, i) == P2M_PP || fld(p2_cfg, i) == P2M_OD;
			p2_od[i] = fld(p2_cfg, i) == P2M_OD;
			p2_pu[i] = fld(p2_cfg, i) == P2M_IN_PU;
			p2_adc_sel[i] = 1'b0;
			p2_alt_val[i] = p2_data_r[i];
		end
		// pin six: three-bit field
		p2_drv[6] = p26_mode[2];
		p2_od[6] = p26_mode == P26_OD_PU || p26_mode == P26_OD;
		p2_pu[6] = p26_mode == P26_IN_PU || p26_mode == P26_OD_PU;
		p2_adc_sel[6] = p26_mode[2:1] == 2'h1;
		p2_alt_val[6] = (p26_mode == P26_CLO) ? clo_val : p2_data_r[6];
		// pin zero carries timer match output when its field selects open-drain (alternate)
		if (fld(p2_cfg, 0) == P2M_OD)
			p2_alt_val[0] = tmr_match;
	end

	// ********************************
	// pin drive
	// ********************************
	assign p0_out = p0_alt_sel & p0_pwm | ~p0_alt_sel & p0_data_r[P0_PINS-1:0];
	assign p0_oe_n = ~p0_drv;
	assign p0_irq_pin = p0_sync;

	// port one pin one: osc out by option, else config
	logic p1_mode_out, p1_od;
	logic [1:0] p1_mode;
	assign p1_mode = p1_cfg_r[P1_MODE_LSB +: 2];
	assign p1_mode_out = p1_mode == P1M_OUT;
	assign p1_od = p1_cfg_r[P1_OD_BIT];
	// open-drain only ever pulls low
	assign p1_out[0] = opt_osc_en ? osc_clk_out : (p1_od ? 1'b0 : p1_data_r[0]);
	assign p1_oe_n[0] = opt_osc_en ? 1'b0 : ~(p1_mode_out && !(p1_od && p1_data_r[0]));
	assign p1_pu[0] = !opt_osc_en && p1_mode == P1M_IN_PU;
	assign p1_pd[0] = !opt_osc_en && p1_mode == P1M_IN_PD;
	// reset-capable pin is input only
	assign p1_out[1] = 1'b0;
	assign p1_oe_n[1] = 1'b1;
	assign p1_pu[1] = 1'b0;
	assign p1_pd[1] = 1'b0;
	assign ext_reset_n = opt_rst_en ? p1_sync[1] : 1'b1;

	always_comb
	begin
		for (int i = 0; i < P2_PINS; i++)
		begin
			p2_out[i] = p2_od[i] ? 1'b0 : p2_alt_val[i];
			p2_oe_n[i] = ~(p2_drv[i] && !(p2_od[i] && p2_alt_val[i]));
		end
	end

	// ********************************
	// read mux
	// ********************************
	function automatic logic [7:0] mix(input logic [7:0] d, input logic [7:0] s,
		input logic [7:0] o);
		mix = (d & o) | (s & ~o);
	endfunction

	logic [7:0] p0_rd, p1_rd, p2_rd;
	assign p0_rd = mix(p0_data_r, p0_sync, p0_drv);
	assign p1_rd = mix({6'h00, p1_data_r[1:0]}, {6'h00, p1_sync},
		{7'h00, p1_mode_out && !opt_osc_en});
	assign p2_rd = mix({1'b0, p2_data_r[6:0]}, {1'b0, p2_sync}, {1'b0, p2_drv});

	always_comb
	begin
		rdata_nxt = 8'h00;
		if (rd)
		begin
			case (addr)
				ADDR_P0_DATA: rdata_nxt = p0_rd;
				ADDR_P1_DATA: rdata_nxt = p1_rd;
				ADDR_P2_DATA: rdata_nxt = p2_rd;
				ADDR_P0_CFGH: rdata_nxt = p0_cfgh_r;
				ADDR_P0_CFGL: rdata_nxt = p0_cfgl_r;
				ADDR_P0_PEND: rdata_nxt = p0_pend_r;
				ADDR_P1_CFG: rdata_nxt = p1_cfg_r;
				ADDR_P2_CFGH: rdata_nxt = p2_cfgh_r;
				ADDR_P2_CFGL: rdata_nxt = p2_cfgl_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end
	assign rdata = rdata_r;

	// ********************************
	// checks
	// ********************************
	a_reset_pin_input: assert property (@(posedge clk) disable iff (!rst_n)
		p1_oe_n[1] && !p1_out[1]) else $error("reset pin driven");
	a_p0_write_read: assert property (@(posedge clk) disable iff (!rst_n)
		w_p0 ##1 (rd && addr == ADDR_P0_DATA && p0_drv == 8'hFF && !wr) |=> rdata == $past(p0_data_r))
		else $error("port zero readback wrong");
	a_p1_od_mode: assert property (@(posedge clk) disable iff (!rst_n)
		(!opt_osc_en && p1_od) |-> !p1_out[0]) else $error("open drain drives high");
	a_p1_out_mode: assert property (@(posedge clk) disable iff (!rst_n)
		(!opt_osc_en && p1_mode != P1M_OUT) |-> p1_oe_n[0]) else $error("input pin driving");
	a_p1_pulls: assert property (@(posedge clk) disable iff (!rst_n)
		!(p1_pu[0] && p1_pd[0])) else $error("both pulls on");
	a_p2_six_adc: assert property (@(posedge clk) disable iff (!rst_n)
		p2_adc_sel[6] |-> p2_oe_n[6]) else $error("adc pin driving");
	a_cfg_write: assert property (@(posedge clk) disable iff (!rst_n)
		w_p1c |=> p1_cfg_r == $past(wdata)) else $error("config write lost");
	a_input_read: assert property (@(posedge clk) disable iff (!rst_n)
		(rd && addr == ADDR_P2_DATA && p2_drv == 7'h00) |=> rdata == {1'b0, $past(p2_sync)})
		else $error("input read wrong");
	a_p0_pullup: assert property (@(posedge clk) disable iff (!rst_n)
		(p0_pu != 8'h00) |-> ((p0_pu & p0_drv) == 8'h00)) else $error("pull on driver");

	// ********************************
	// pin drive, sync and register checks
	// ********************************
	a_p0_data_out: assert property (@(posedge clk) disable iff (!rst_n)
		((p0_out ^ p0_data_r) & ~p0_alt_sel) == 8'h00)
		else $error("port zero output differs from data");
	a_p0_alt_pwm: assert property (@(posedge clk) disable iff (!rst_n)
		((p0_out ^ p0_pwm) & p0_alt_sel) == 8'h00)
		else $error("port zero alternate output wrong");
	a_data_reset: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> {p0_data_r, p1_data_r, p2_data_r} == {3{RST_DATA}})
		else $error("data register not cleared by reset");
	a_osc_out: assert property (@(posedge clk) disable iff (!rst_n)
		opt_osc_en |-> (!p1_oe_n[0] && p1_out[0] == osc_clk_out && !p1_pu[0] && !p1_pd[0]))
		else $error("oscillator output not on pin");
	a_ext_reset_off: assert property (@(posedge clk) disable iff (!rst_n)
		!opt_rst_en |-> ext_reset_n)
		else $error("reset pin active while not selected");
	// sync flops restart from zero, so both checks skip two cycles after reset
	a_ext_reset_on: assert property (@(posedge clk) disable iff (!rst_n)
		($past(rst_n, 2) && opt_rst_en) |-> ext_reset_n == $past(p1_in[1], 2))
		else $error("reset pin level not passed on");
	a_pin_sync: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n, 2) |->
		{p2_sync, p1_sync, p0_irq_pin} == $past({p2_in, p1_in, p0_in}, 2))
		else $error("pin levels not two flops late");
	// open-drain pins only ever pull low
	a_p2_od_drive: assert property (@(posedge clk) disable iff (!rst_n)
		(p2_od & ~p2_oe_n & (p2_out | p2_alt_val)) == 7'h00)
		else $error("open drain pin drives high");
	a_p2_clo: assert property (@(posedge clk) disable iff (!rst_n)
		(p26_mode == P26_CLO) |-> (!p2_oe_n[6] && p2_out[6] == clo_val))
		else $error("clock output not on pin six");
	a_p2_timer: assert property (@(posedge clk) disable iff (!rst_n)
		(fld(p2_cfg, 0) == P2M_OD) |-> (p2_oe_n[0] == tmr_match && !p2_out[0]))
		else $error("timer match not on pin zero");
	a_p2_push_pull: assert property (@(posedge clk) disable iff (!rst_n)
		(fld(p2_cfg, 1) == P2M_PP) |-> (!p2_oe_n[1] && p2_out[1] == p2_data_r[1]))
		else $error("port two push-pull pin wrong");
	a_p2_pin_four: assert property (@(posedge clk) disable iff (!rst_n)
		(fld(p2_cfg, 4) == P2M_IN_PU) |-> (p2_pu[4] && p2_oe_n[4]))
		else $error("pin four pull-up input wrong");
	// read data stands one cycle only, zero otherwise
	a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!rd |=> rdata == 8'h00)
		else $error("read data without a read");
	a_p1_od_release: assert property (@(posedge clk) disable iff (!rst_n)
		(!opt_osc_en && p1_mode_out && p1_od && p1_data_r[0]) |-> p1_oe_n[0])
		else $error("open drain pin not released");
	a_p1_pull_down: assert property (@(posedge clk) disable iff (!rst_n)
		(!opt_osc_en && p1_mode == P1M_IN_PD) |-> (p1_pd[0] && p1_oe_n[0] && !p1_pu[0]))
		else $error("pull-down input mode wrong");
	a_p1_read: assert property (@(posedge clk) disable iff (!rst_n)
		(rd && addr == ADDR_P1_DATA && !p1_mode_out) |=> rdata == {6'h00, $past(p1_sync)})
		else $error("port one input read wrong");
	a_p0_cfg_write: assert property (@(posedge clk) disable iff (!rst_n)
		w_p0h |=> p0_cfgh_r == $past(wdata))
		else $error("port zero config write lost");
	a_p2_cfg_write: assert property (@(posedge clk) disable iff (!rst_n)
		w_p2l |=> p2_cfgl_r == $past(wdata))
		else $error("port two config write lost");
	a_p1_data_write: assert property (@(posedge clk) disable iff (!rst_n)
		w_p1 |=> p1_data_r == $past(wdata))
		else $error("port one data write lost");
	a_p2_data_write: assert property (@(posedge clk) disable iff (!rst_n)
		w_p2 |=> p2_data_r == $past(wdata))
		else $error("port two data write lost");
endmodule // tpg_gpio

// File: bench/tpg_gpio_tb.sv
// Purpose: self-checking bench for the three-port gpio block
// Assumes: reads answer one cycle after the strobe; pins pass two sync flops
// Notes: pin changes wait three cycles before a read so the sync chain settles
module tpg_gpio_tb
	import tpg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// signals
	// ****************************************
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] p0_in = 8'h00;
	logic [7:0] p0_pwm = 8'h00;
	logic [1:0] p1_in = 2'h0;
	logic opt_osc_en = 1'b0;
	logic opt_rst_en = 1'b0;
	logic osc_clk_out = 1'b0;
	logic [6:0] p2_in = 7'h00;
	logic clo_val = 1'b0;
	logic tmr_match = 1'b0;
	logic [7:0] rdata, p0_out, p0_oe_n, p0_pu, p0_alt_sel, p0_irq_pin;
	logic [1:0] p1_out, p1_oe_n, p1_pu, p1_pd;
	logic ext_reset_n;
	logic [6:0] p2_out, p2_oe_n, p2_pu, p2_adc_sel;
	int mismatches = 0;
	int checked = 0;
	logic [7:0] cfg_a [6] = '{ADDR_P0_CFGH, ADDR_P0_CFGL, ADDR_P0_PEND, ADDR_P1_CFG,
		ADDR_P2_CFGH, ADDR_P2_CFGL};
	logic [7:0] cfg_v [6] = '{8'hA5, 8'h5A, 8'h0A, 8'h8C, 8'h4B, 8'hC3};
	// packed as pull-up, pull-down, pin two enable, pin one enable, driven value
	logic [7:0] p1c [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h88};
	logic [7:0] p1e [5] = '{8'h06, 8'h16, 8'h05, 8'h0E, 8'h06};
	logic [2:0] p6c [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
	logic [7:0] p6e [8] = '{8'h0A, 8'h02, 8'h06, 8'h06, 8'h01, 8'h0A, 8'h02, 8'h00};

	always #2 clk = ~clk;

	tpg_gpio u_dut (
		.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .p0_in(p0_in), .p0_out(p0_out), .p0_oe_n(p0_oe_n), .p0_pu(p0_pu),
		.p0_alt_sel(p0_alt_sel), .p0_irq_pin(p0_irq_pin), .p0_pwm(p0_pwm), .p1_in(p1_in),
		.p1_out(p1_out), .p1_oe_n(p1_oe_n), .p1_pu(p1_pu), .p1_pd(p1_pd),
		.opt_osc_en(opt_osc_en), .opt_rst_en(opt_rst_en), .osc_clk_out(osc_clk_out),
		.ext_reset_n(ext_reset_n), .p2_in(p2_in), .p2_out(p2_out), .p2_oe_n(p2_oe_n),
		.p2_pu(p2_pu), .p2_adc_sel(p2_adc_sel), .clo_val(clo_val), .tmr_match(tmr_match)
	);
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		if (mismatches == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic do_reset;
		@(posedge clk);
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		// internal copy frees on the second edge, first access on the third
		repeat (3) @(posedge clk);
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		do_reset();
		reg_rd(ADDR_P0_DATA, RST_DATA);
		reg_rd(ADDR_P1_DATA, RST_DATA);
		reg_rd(ADDR_P2_DATA, RST_DATA);
		for (int i = 0; i < 6; i++)
		begin
			reg_rd(cfg_a[i], RST_CFG);
			reg_wr(cfg_a[i], cfg_v[i]);
			reg_rd(cfg_a[i], cfg_v[i]);
		end
		// unmapped place must neither store nor answer
		reg_wr(8'hE3, 8'hFF);
		reg_rd(8'hE3, 8'h00);
		reg_wr(ADDR_P0_CFGH, 8'hAA);
		reg_wr(ADDR_P0_CFGL, 8'hAA);
		reg_wr(ADDR_P0_DATA, 8'h5A);
		chk(p0_out, 8'h5A);
		chk(p0_oe_n, 8'h00);
		reg_rd(ADDR_P0_DATA, 8'h5A);
		// write then read with no gap between the strobes
		@(posedge clk);
		addr <= ADDR_P0_DATA;
		wdata <= 8'h3C;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, 8'h3C);
		@(posedge clk);
		p0_in <= 8'hC3;
		p0_pwm <= 8'h3C;
		reg_wr(ADDR_P0_CFGH, 8'h55);
		reg_wr(ADDR_P0_CFGL, 8'h55);
		settle();
		chk(p0_pu, 8'hFF);
		chk(p0_oe_n, 8'hFF);
		chk(p0_irq_pin, 8'hC3);
		reg_rd(ADDR_P0_DATA, 8'hC3);
		reg_wr(ADDR_P0_CFGH, 8'hFF);
		reg_wr(ADDR_P0_CFGL, 8'hFF);
		chk(p0_alt_sel, 8'hFF);
		chk(p0_out, 8'h3C);
		reg_wr(ADDR_P1_DATA, 8'h03);
		for (int i = 0; i < 5; i++)
		begin
			reg_wr(ADDR_P1_CFG, p1c[i]);
			chk({3'h0, p1_pu[0], p1_pd[0], p1_oe_n, p1_out[0] & ~p1_oe_n[0]}, p1e[i]);
		end
		// open drain pulls low once the data bit is zero
		reg_wr(ADDR_P1_DATA, 8'h00);
		chk({5'h0, p1_oe_n, p1_out[0]}, 8'h04);
		reg_wr(ADDR_P1_CFG, 8'h08);
		@(posedge clk);
		opt_osc_en <= 1'b1;
		osc_clk_out <= 1'b1;
		#1 chk({7'h0, p1_out[0]}, 8'h01);
		@(posedge clk);
		osc_clk_out <= 1'b0;
		#1 chk({7'h0, p1_out[0]}, 8'h00);
		@(posedge clk);
		opt_rst_en <= 1'b1;
		settle();
		chk({7'h0, ext_reset_n}, 8'h00);
		chk({6'h0, p1_oe_n[1], 1'b0}, 8'h02);
		@(posedge clk);
		p1_in <= 2'h2;
		settle();
		chk({7'h0, ext_reset_n}, 8'h01);
		reg_wr(ADDR_P2_CFGL, 8'hAA);
		reg_wr(ADDR_P2_CFGH, 8'h4A);
		reg_wr(ADDR_P2_DATA, 8'h55);
		chk({1'b0, p2_out}, 8'h55);
		chk({1'b0, p2_oe_n}, 8'h00);
		reg_rd(ADDR_P2_DATA, 8'h55);
		reg_wr(ADDR_P2_DATA, 8'h00);
		for (int c = 0; c < 4; c++)
		begin
			reg_wr(ADDR_P2_CFGH, {4'h0, c[1:0], c[1:0]});
			chk({4'h0, p2_pu[5:4], p2_oe_n[5:4]}, {4'h0, (c == 0) ? 2'h3 : 2'h0,
				(c >= 2) ? 2'h0 : 2'h3});
		end
		// data bit set high so the clock code shows it is not the data bit
		reg_wr(ADDR_P2_DATA, 8'h40);
		for (int i = 0; i < 8; i++)
		begin
			reg_wr(ADDR_P2_CFGH, {1'b0, p6c[i], 4'h0});
			chk({4'h0, p2_pu[6], p2_adc_sel[6], p2_oe_n[6], p2_out[6] & ~p2_oe_n[6]},
				p6e[i]);
		end
		// clock code left selected: the pin now follows the clock value
		@(posedge clk);
		clo_val <= 1'b1;
		#1 chk({7'h0, p2_out[6]}, 8'h01);
		reg_wr(ADDR_P2_CFGL, 8'h03);
		chk({6'h0, p2_oe_n[0], p2_out[0]}, 8'h00);
		@(posedge clk);
		tmr_match <= 1'b1;
		#1 chk({6'h0, p2_oe_n[0], p2_out[0]}, 8'h02);
		reg_wr(ADDR_P2_CFGL, 8'h55);
		reg_wr(ADDR_P2_CFGH, 8'h15);
		@(posedge clk);
		p2_in <= 7'h2D;
		settle();
		chk({1'b0, p2_pu}, 8'h00);
		reg_rd(ADDR_P2_DATA, 8'h2D);
		reg_wr(ADDR_P0_DATA, 8'hFF);
		do_reset();
		reg_wr(ADDR_P0_CFGH, 8'hAA);
		reg_wr(ADDR_P0_CFGL, 8'hAA);
		chk(p0_out, 8'h00);
		end_sim();
	end

	initial
	begin
		#20000;
		mismatches++;
		end_sim();
	end
endmodule // tpg_gpio_tb
